// *** src/cpu_clock_pkg.sv ***
package cpu_clock_pkg;
   localparam int CORE_CLK_MHZ = 40;
   localparam int PERIOD_W = 12;
   localparam int THRESH_W = 14;
   localparam int ACC_W = 16;
   localparam logic [1:0] BYPASS_DIV_1 = 2'h0;
   localparam logic [1:0] BYPASS_DIV_2 = 2'h1;
   localparam logic [1:0] BYPASS_DIV_4 = 2'h2;
   localparam logic [4:0] MULT_MIN = 5'h02;
   localparam logic [4:0] MULT_MAX = 5'h1F;
   localparam logic [1:0] RST_BYPASS_DIV = BYPASS_DIV_1;
   localparam logic [4:0] RST_MULT = MULT_MIN;
   localparam logic [1:0] RST_SYNTH_DIV = 2'h0;
   localparam logic RST_LOCK_MODE = 1'b0;
   localparam logic RST_OSC_ENABLE = 1'b1;
   localparam int CPU_PERIOD_MAX_NS = 1600;
   localparam int CPU_PERIOD_MAX_CYC = (CPU_PERIOD_MAX_NS * CORE_CLK_MHZ) / 1000;
endpackage

// *** src/cpu_clock_generator.sv ***
`timescale 1ns/1ps
module cpu_clock_generator (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_reference_clock_input,
   input wire logic i_osc_stop_req,
   input wire logic i_lock_mode,
   input wire logic [1:0] i_bypass_div,
   input wire logic [4:0] i_synth_multiply_field,
   input wire logic [1:0] i_synth_divide_field,
   output logic o_cpu_clock_output,
   output logic o_crystal_drive_pin,
   output logic o_osc_enable,
   output logic o_synth_enable
);
   import cpu_clock_pkg::*;

   typedef struct packed {
      logic ref_q;
      logic [cpu_clock_pkg::PERIOD_W-1:0] cnt;
      logic [cpu_clock_pkg::PERIOD_W-1:0] period;
      logic [cpu_clock_pkg::ACC_W-1:0] acc;
      logic bcnt;
      logic act_lock;
      logic [1:0] act_bdiv;
      logic [4:0] act_mult;
      logic [1:0] act_ldiv;
      logic clk_out;
      logic drive;
      logic osc_en;
      logic synth_en;
   } state_t;

   state_t st;
   state_t next_st;
   logic ref_rise;
   logic [cpu_clock_pkg::THRESH_W-1:0] thresh;
   logic [cpu_clock_pkg::ACC_W-1:0] acc_sum;
   logic lock_toggle;
   logic apply_cfg;
   logic [cpu_clock_pkg::ACC_W-1:0] acc_rem;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      ref_rise = i_reference_clock_input & ~st.ref_q;
      thresh = THRESH_W'(st.period * ({1'b0, st.act_ldiv} + 3'h1));
      acc_sum = st.acc + ACC_W'({st.act_mult, 1'b0});
      lock_toggle = (thresh != '0) && (acc_sum >= ACC_W'(thresh));
      acc_rem = acc_sum - ACC_W'(thresh);
      next_st = st;
      next_st.ref_q = i_reference_clock_input;
      // Reference period is measured in core cycles for the synthesizer.
      if (ref_rise) begin
         next_st.cnt = '0;
         next_st.period = st.cnt + PERIOD_W'(1);
      end else if (st.cnt != '1) begin
         next_st.cnt = st.cnt + PERIOD_W'(1);
      end
      if (st.act_lock) begin
         // Two toggles per output period, so the step is twice the multiplier.
         if (lock_toggle) begin
            // Past the core rate the remainder is capped, so the sum never wraps.
            next_st.acc = (acc_rem > ACC_W'(thresh)) ? ACC_W'(thresh) : acc_rem;
            next_st.clk_out = ~st.clk_out;
         end else if (thresh != '0) begin
            next_st.acc = acc_sum;
         end
         next_st.bcnt = 1'b0;
      end else begin
         case (st.act_bdiv)
            BYPASS_DIV_1: next_st.clk_out = i_reference_clock_input;
            BYPASS_DIV_2: if (ref_rise) next_st.clk_out = ~st.clk_out;
            default: begin
               if (ref_rise) begin
                  next_st.bcnt = ~st.bcnt;
                  if (st.bcnt) next_st.clk_out = ~st.clk_out;
               end
            end
         endcase
         next_st.acc = '0;
      end
      // New settings take effect only as a high phase ends, or while a lock
      // synthesizer is still idle low, so no high phase is ever cut short.
      apply_cfg = (st.clk_out && !next_st.clk_out) ||
                  (!st.clk_out && st.act_lock && thresh == '0);
      if (apply_cfg) begin
         next_st.act_lock = i_lock_mode;
         next_st.act_bdiv = (i_bypass_div == 2'h3) ? BYPASS_DIV_4 : i_bypass_div;
         next_st.act_mult = (i_synth_multiply_field < MULT_MIN) ? MULT_MIN
                                                                 : i_synth_multiply_field;
         next_st.act_ldiv = i_synth_divide_field;
         // The remainder is kept while the ratio stays, so N is exact on average.
         if (next_st.act_lock != st.act_lock || next_st.act_mult != st.act_mult ||
             next_st.act_ldiv != st.act_ldiv) begin
            next_st.acc = '0;
         end
         next_st.bcnt = 1'b0;
      end
      next_st.synth_en = next_st.act_lock;
      next_st.osc_en = ~i_osc_stop_req;
      next_st.drive = next_st.osc_en & ~i_reference_clock_input;
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= '0;
         st.act_lock <= RST_LOCK_MODE;
         st.act_bdiv <= RST_BYPASS_DIV;
         st.act_mult <= RST_MULT;
         st.act_ldiv <= RST_SYNTH_DIV;
         st.osc_en <= RST_OSC_ENABLE;
      end else begin
         st <= next_st;
      end
   end

   assign o_cpu_clock_output = st.clk_out;
   assign o_crystal_drive_pin = st.drive;
   assign o_osc_enable = st.osc_en;
   assign o_synth_enable = st.synth_en;

   ////////////////////////////////////////////////////////////////////////////////
   property p_osc_after_reset;
      @(posedge i_core_clk) (!i_sys_rst && $past(i_sys_rst)) |-> o_osc_enable;
   endproperty
   a_osc_after_reset: assert property (p_osc_after_reset)
      else $error("Oscillator not running after reset.");

   property p_bypass_div1;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (!i_sys_rst && !st.act_lock && st.act_bdiv == BYPASS_DIV_1 && !apply_cfg)
         |=> (o_cpu_clock_output == $past(i_reference_clock_input));
   endproperty
   a_bypass_div1: assert property (p_bypass_div1)
      else $error("Bypass divide-by-one does not follow the reference.");

   sequence s_ref_rise_div2;
      !st.act_lock && st.act_bdiv == BYPASS_DIV_2 && ref_rise && !apply_cfg;
   endsequence
   property p_bypass_div2;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      s_ref_rise_div2 |=> $changed(o_cpu_clock_output);
   endproperty
   a_bypass_div2: assert property (p_bypass_div2)
      else $error("Bypass divide-by-two missed a toggle.");

   property p_lock_ignores_bdiv;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      st.act_lock |-> !st.bcnt;
   endproperty
   a_lock_ignores_bdiv: assert property (p_lock_ignores_bdiv)
      else $error("Bypass divider active in lock mode.");

   property p_synth_off_in_bypass;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      !st.act_lock |-> (!o_synth_enable && st.acc == '0);
   endproperty
   a_synth_off_in_bypass: assert property (p_synth_off_in_bypass)
      else $error("Synthesis running in bypass mode.");

   property p_lock_toggle;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (st.act_lock && lock_toggle) |=> $changed(o_cpu_clock_output);
   endproperty
   a_lock_toggle: assert property (p_lock_toggle)
      else $error("Lock synthesizer missed a toggle.");

   property p_switch_clean;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      $changed(st.act_lock) |-> ($fell(o_cpu_clock_output) || !o_cpu_clock_output);
   endproperty
   a_switch_clean: assert property (p_switch_clean)
      else $error("Mode switched during a high phase.");

   property p_lock_only_synth;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (st.act_lock && !lock_toggle) |=> $stable(o_cpu_clock_output);
   endproperty
   a_lock_only_synth: assert property (p_lock_only_synth)
      else $error("CPU clock moved in lock mode without a synthesizer toggle.");

   sequence s_ref_hold_div4;
      !st.act_lock && st.act_bdiv == BYPASS_DIV_4 && !(ref_rise && st.bcnt);
   endsequence
   property p_bypass_div4;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      s_ref_hold_div4 |=> $stable(o_cpu_clock_output);
   endproperty
   a_bypass_div4: assert property (p_bypass_div4)
      else $error("Bypass divide-by-four toggled on the wrong reference edge.");

   property p_cfg_held_high;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_cpu_clock_output && next_st.clk_out)
         |=> ($stable(st.act_lock) && $stable(st.act_bdiv) &&
              $stable(st.act_mult) && $stable(st.act_ldiv));
   endproperty
   a_cfg_held_high: assert property (p_cfg_held_high)
      else $error("Clock settings changed during a high phase.");

   property p_synth_on_in_lock;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      st.act_lock |-> o_synth_enable;
   endproperty
   a_synth_on_in_lock: assert property (p_synth_on_in_lock)
      else $error("Synthesis flag low while lock mode is active.");

   property p_osc_running;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (!i_sys_rst && !i_osc_stop_req)
         |=> (o_osc_enable && o_crystal_drive_pin == !$past(i_reference_clock_input));
   endproperty
   a_osc_running: assert property (p_osc_running)
      else $error("Oscillator drive does not follow the reference.");

   property p_osc_stopped;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (!i_sys_rst && i_osc_stop_req) |=> (!o_osc_enable && !o_crystal_drive_pin);
   endproperty
   a_osc_stopped: assert property (p_osc_stopped)
      else $error("Oscillator still driven after a stop request.");
endmodule

// *** tb/ref_clock_source.sv ***
`timescale 1ns/1ps
// Free-running reference, as a crystal keeps oscillating between frames.
module ref_clock_source #(parameter int HALF = 8) (
   input wire logic i_core_clk,
   output logic o_ref
);
   int cnt = 0;
   logic level = 1'b0;
   assign o_ref = level;
   always @(posedge i_core_clk) begin
      if (cnt == HALF - 1) begin
         cnt <= 0;
         level <= ~level;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// *** tb/cpu_clock_generator_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
   $display("[ERR] %0t value mismatch", $time); end end
module cpu_clock_generator_tb;
   import cpu_clock_pkg::*;
   logic clk, rst, ref_clk, stop, lock, out, drv, osc, synth;
   logic [1:0] bdiv, sdiv;
   logic [4:0] mult;
   int mismatches = 0;
   int check_count = 0;
   ref_clock_source #(.HALF(8)) src (.i_core_clk(clk), .o_ref(ref_clk));
   cpu_clock_generator dut (.i_core_clk(clk), .i_sys_rst(rst), .i_reference_clock_input(ref_clk),
      .i_osc_stop_req(stop), .i_lock_mode(lock), .i_bypass_div(bdiv),
      .i_synth_multiply_field(mult), .i_synth_divide_field(sdiv), .o_cpu_clock_output(out),
      .o_crystal_drive_pin(drv), .o_osc_enable(osc), .o_synth_enable(synth));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Counts core cycles between two rising edges of the CPU clock.
   task automatic measure(input int exp_cyc);
      int k;
      int r;
      int p;
      logic prev;
      r = 0;
      p = 0;
      #1;
      prev = out;
      for (k = 0; k < 400 && r < 2; k++) begin
         @(posedge clk);
         #1;
         if (r == 1) p++;
         if (out && !prev) r++;
         prev = out;
      end
      if (r < 2) begin
         mismatches++;
         conclude();
      end
      `CHK(p, exp_cyc)
   endtask
   task automatic t_reset;
      `CHK(osc, 1'b1)
      `CHK(out, 1'b0)
      `CHK(synth, 1'b0)
      @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `CHK(osc, 1'b1)
   endtask
   // Drive pin, oscillator stop request and a reset in mid-run.
   task automatic t_osc;
      logic last_ref;
      @(posedge clk);
      #1;
      last_ref = ref_clk;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         #1;
         `CHK(drv, ~last_ref)
         last_ref = ref_clk;
      end
      @(posedge clk);
      stop <= 1'b1;
      @(posedge clk);
      #1;
      `CHK(osc, 1'b0)
      `CHK(drv, 1'b0)
      @(posedge clk);
      rst <= 1'b1;
      #1;
      `CHK(osc, 1'b1)
      `CHK(out, 1'b0)
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      stop <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK(osc, 1'b1)
   endtask
   task automatic t_bypass;
      logic [1:0] codes [4] = '{BYPASS_DIV_1, BYPASS_DIV_2, BYPASS_DIV_4, 2'h3};
      int exp_cyc [4] = '{16, 32, 64, 64};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         bdiv <= codes[i];
         mult <= 5'h1F;
         repeat (200) @(posedge clk);
         measure(exp_cyc[i]);
         `CHK(synth, 1'b0)
      end
   endtask
   task automatic t_lock;
      int tab [3][3] = '{'{4, 1, 8}, '{2, 3, 32}, '{31, 0, 2}};
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         lock <= 1'b1;
         bdiv <= 2'(i);
         mult <= 5'(tab[i][0]);
         sdiv <= 2'(tab[i][1]);
         repeat (200) @(posedge clk);
         measure(tab[i][2]);
         `CHK(synth, 1'b1)
      end
   endtask
   initial begin
      rst = 1'b1;
      stop = 1'b0;
      lock = 1'b0;
      bdiv = BYPASS_DIV_1;
      sdiv = 2'h0;
      mult = MULT_MIN;
      @(posedge clk);
      #1;
      t_reset();
      t_osc();
      t_bypass();
      t_lock();
      conclude();
   end
endmodule
